// ===== rapw_regs.vh
// Constants for the reset and powerdown wake sequencer
`ifndef RAPW_REGS_VH
`define RAPW_REGS_VH
`define RAPW_PULL_STATES   5'h10
`define RAPW_STATE_CLKS    2'h2
`define RAPW_LOCK_MS       2
`define RAPW_CLK_HZ        25000000
`define RAPW_RESET_FETCH   24'hff2080
`define RAPW_EXT_FETCH     20'hf2080
`define RAPW_EXT_LO        24'hff2000
`define RAPW_EXT_HI        24'hff2fff
`define RAPW_CMS_STD       2'h0
`define RAPW_CMS_TEST      2'h1
`define RAPW_CMS_DBL       2'h2
`define RAPW_CMS_QUAD      2'h3
`define RAPW_MODE_RUN      2'h0
`define RAPW_MODE_IDLE     2'h1
`define RAPW_MODE_STBY     2'h2
`define RAPW_MODE_PDN      2'h3
`define RAPW_WAKE_DEF      16'h0400
`endif

// ===== rapw_pull_timer.v
// Pull-down pulse timer counting state times
`include "rapw_regs.vh"
module rapw_pull_timer (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       rstn,
	input  wire       ce,
	// Control
	input  wire       trigger,
	output reg        pull_r
);
	reg [4:0] states_r;
	reg [1:0] phase_r;

	always @(posedge clk_sys) begin
		if (!rstn) begin
			states_r <= 5'h00;
			phase_r  <= 2'h0;
			pull_r   <= 1'b0;
		end else if (ce) begin
			if (trigger) begin
				states_r <= `RAPW_PULL_STATES;
				phase_r  <= 2'h0;
				pull_r   <= 1'b1;
			end else if (states_r != 5'h00) begin
				if (phase_r == `RAPW_STATE_CLKS - 2'h1) begin
					phase_r  <= 2'h0;
					states_r <= states_r - 5'h01;
					if (states_r == 5'h01)
						pull_r <= 1'b0;
				end else begin
					phase_r <= phase_r + 2'h1;
				end
			end
		end
	end
endmodule // rapw_pull_timer

// ===== rapw_seq.v
// Reset and powerdown wake sequencer top
// Contract
// - Reset pin is level input and open-drain output
// - Pin edge or internal reset pulls 16 states
// - Reset pin in low power forces full reset
// - First fetch after reset at FF2080H
// - FF2000 to FF2FFFH map to external memory
// - Clocks held off until wake delay ends
// - Multiplier select: standard, doubled, quadrupled, test
`include "rapw_regs.vh"
module rapw_seq #(
	parameter WAKE_W = 16,
	parameter LOCK_CLKS = `RAPW_LOCK_MS * (`RAPW_CLK_HZ / 1000)
) (
	// Clock and reset
	input  wire              clk_sys,
	input  wire              rstn,
	input  wire              ce,
	// Reset pin, open drain
	input  wire              rst_pin_in,
	output reg               rst_pin_out_r,
	output reg               rst_pin_oe_r,
	// Internal reset sources and mode
	input  wire              int_reset_req,
	input  wire [1:0]        mode_req,
	input  wire              wake_event,
	// Wake timing and multiplier select
	input  wire [WAKE_W-1:0] powerdown_wake_timing,
	input  wire [1:0]        clock_multiplier_select,
	// Address check
	input  wire [23:0]       fetch_addr,
	// Outputs
	output reg               core_reset_n_r,
	output reg               clk_enable_r,
	output reg  [1:0]        clk_mult_r,
	output reg               pll_enable_r,
	output reg               test_mode_r,
	output reg  [1:0]        mode_r,
	output reg  [23:0]       reset_vector_r,
	output reg  [19:0]       ext_vector_r,
	output reg               addr_external_r,
	output reg               pull_active_r
);
	localparam S_RUN  = 2'h0;
	localparam S_LOW  = 2'h1;
	localparam S_WAKE = 2'h2;

	reg              pin_q_r;
	reg [1:0]        st_r;
	reg [WAKE_W-1:0] wake_cnt_r;
	wire             pull;

	function is_ext;
		input [23:0] a;
		is_ext = (a >= `RAPW_EXT_LO) && (a <= `RAPW_EXT_HI);
	endfunction

	// Falling edge of the pin starts the pull; own pull then holds it low
	// Own pull is masked so that it cannot retrigger itself and stretch the pulse
	wire pin_fall = pin_q_r & ~rst_pin_in & ~rst_pin_oe_r;

	rapw_pull_timer u_pull (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.trigger (pin_fall | int_reset_req),
		.pull_r  (pull)
	);

	always @(posedge clk_sys) begin
		if (!rstn) begin
			pin_q_r         <= 1'b1;
			// Leave reset through the pin check so the core starts once the pin is high
			st_r            <= S_LOW;
			wake_cnt_r      <= {WAKE_W{1'b0}};
			rst_pin_out_r   <= 1'b0;
			rst_pin_oe_r    <= 1'b0;
			core_reset_n_r  <= 1'b0;
			clk_enable_r    <= 1'b0;
			clk_mult_r      <= `RAPW_CMS_STD;
			pll_enable_r    <= 1'b0;
			test_mode_r     <= 1'b0;
			mode_r          <= `RAPW_MODE_RUN;
			reset_vector_r  <= `RAPW_RESET_FETCH;
			ext_vector_r    <= `RAPW_EXT_FETCH;
			addr_external_r <= 1'b0;
			pull_active_r   <= 1'b0;
		end else if (ce) begin
			pin_q_r        <= rst_pin_in;
			rst_pin_out_r  <= 1'b0;
			rst_pin_oe_r   <= pull;
			pull_active_r  <= pull;
			reset_vector_r <= `RAPW_RESET_FETCH;
			ext_vector_r   <= `RAPW_EXT_FETCH;
			addr_external_r <= is_ext(fetch_addr);
			clk_mult_r     <= clock_multiplier_select;
			pll_enable_r   <= (clock_multiplier_select == `RAPW_CMS_DBL) ||
				(clock_multiplier_select == `RAPW_CMS_QUAD);
			test_mode_r    <= (clock_multiplier_select == `RAPW_CMS_TEST);
			case (st_r)
				S_RUN: begin
					if (!rst_pin_in || pull) begin
						// Any mode, powerdown included, drops to full reset
						st_r           <= S_LOW;
						core_reset_n_r <= 1'b0;
						mode_r         <= `RAPW_MODE_RUN;
						clk_enable_r   <= 1'b0;
					end else if (mode_r == `RAPW_MODE_PDN && wake_event) begin
						st_r         <= S_WAKE;
						wake_cnt_r   <= powerdown_wake_timing;
						mode_r       <= `RAPW_MODE_RUN;
					end else if (mode_r == `RAPW_MODE_RUN) begin
						mode_r       <= mode_req;
						clk_enable_r <= (mode_req == `RAPW_MODE_RUN) ||
							(mode_req == `RAPW_MODE_IDLE);
					end else begin
						if (wake_event && mode_r != `RAPW_MODE_PDN) begin
							mode_r       <= `RAPW_MODE_RUN;
							clk_enable_r <= 1'b1;
						end
					end
				end
				S_LOW: begin
					// Pin low time is the board's lock wait for the multiplier
					if (rst_pin_in && !pull) begin
						st_r           <= S_RUN;
						core_reset_n_r <= 1'b1;
						clk_enable_r   <= 1'b1;
					end
				end
				S_WAKE: begin
					if (!rst_pin_in || pull) begin
						st_r           <= S_LOW;
						core_reset_n_r <= 1'b0;
					end else if (wake_cnt_r == {WAKE_W{1'b0}}) begin
						st_r         <= S_RUN;
						clk_enable_r <= 1'b1;
					end else begin
						wake_cnt_r <= wake_cnt_r - {{(WAKE_W-1){1'b0}}, 1'b1};
					end
				end
				default: st_r <= S_RUN;
			endcase
		end
	end
endmodule // rapw_seq

// ===== rapw_asserts.sv
// Port checks for the reset and powerdown wake sequencer
module rapw_asserts (
	input wire logic clk_sys, rstn, ce, rst_pin_in, rst_pin_out_r, rst_pin_oe_r, int_reset_req,
	input wire logic core_reset_n_r, pll_enable_r, test_mode_r, addr_external_r, pull_active_r,
	input wire logic [1:0] clock_multiplier_select, clk_mult_r,
	input wire logic [23:0] fetch_addr, reset_vector_r,
	input wire logic [19:0] ext_vector_r
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_od; !rst_pin_out_r; endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_mir; pull_active_r == rst_pin_oe_r; endproperty
	a_mir: assert property (p_mir) else $error("pull flag differs");
	property p_trig; int_reset_req |-> ##[1:2] rst_pin_oe_r; endproperty
	a_trig: assert property (p_trig) else $error("no pull");
	property p_hold; !rst_pin_in && ce |=> !core_reset_n_r; endproperty
	a_hold: assert property (p_hold) else $error("core out early");
	property p_rel; $rose(core_reset_n_r) |-> $past(rst_pin_in) && !$past(rst_pin_oe_r); endproperty
	a_rel: assert property (p_rel) else $error("bad release");
	property p_vec; reset_vector_r == 24'hff2080 && ext_vector_r == 20'hf2080; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_ext; $past(rstn) && $past(ce) |-> addr_external_r ==
		($past(fetch_addr) >= 24'hff2000 && $past(fetch_addr) <= 24'hff2fff); endproperty
	a_ext: assert property (p_ext) else $error("bad map");
	property p_mult; $past(rstn) && $past(ce) |-> clk_mult_r == $past(clock_multiplier_select) &&
		pll_enable_r == clk_mult_r[1] && test_mode_r == (clk_mult_r == 2'h1); endproperty
	a_mult: assert property (p_mult) else $error("bad select");
	property p_frz; !ce |=> $stable(clk_mult_r) && $stable(core_reset_n_r) &&
		$stable(rst_pin_oe_r); endproperty
	a_frz: assert property (p_frz) else $error("state moved while frozen");
	c_rel: cover property ($rose(core_reset_n_r));
	c_pull: cover property ($rose(rst_pin_oe_r));
	c_ext: cover property ($rose(addr_external_r));
endmodule // rapw_asserts
bind rapw_seq rapw_asserts chk_u (.clk_sys, .rstn, .ce, .rst_pin_in, .rst_pin_out_r, .rst_pin_oe_r,
	.int_reset_req, .core_reset_n_r, .pll_enable_r, .test_mode_r, .addr_external_r,
	.pull_active_r, .clock_multiplier_select, .clk_mult_r, .fetch_addr, .reset_vector_r,
	.ext_vector_r);

// ===== rapw_board.sv
// Board reset source holding the pin low
module rapw_board #(parameter int HOLD = 40) (
	input wire logic clk_sys,
	input wire logic go,
	output logic     rst_low_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// Released pin floats to the pull-up
	assign rst_low_n = (cnt == 0);
	// Hold shortened from 2 ms to keep runs brief
	always @(posedge clk_sys) cnt <= go ? HOLD : (cnt > 0 ? cnt - 1 : 0);
endmodule // rapw_board

// ===== tb_reset_and_powerdown_wake.sv
// Bench for the reset and powerdown wake sequencer
module tb_reset_and_powerdown_wake;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rstn = 0, ce = 1, int_reset_req = 0, wake_event = 0, go = 0, board_n;
	logic [1:0] mode_req = 0, clock_multiplier_select = 0, clk_mult_r, mode_r;
	logic [15:0] powerdown_wake_timing = 16'h0010;
	logic [23:0] fetch_addr = 0, reset_vector_r;
	logic [19:0] ext_vector_r;
	logic rst_pin_out_r, rst_pin_oe_r, core_reset_n_r, clk_enable_r, pll_enable_r, test_mode_r;
	logic addr_external_r, pull_active_r;
	wire rst_pin_in = board_n & ~rst_pin_oe_r;
	int fail_count = 0, checked = 0, i;
	logic [23:0] adr [4] = '{24'hff1fff, 24'hff2000, 24'hff2fff, 24'hff3000};
	initial forever #20 clk_sys = ~clk_sys;
	rapw_board #(.HOLD(40)) brd_u (.clk_sys, .go, .rst_low_n(board_n));
	rapw_seq dut_u (.clk_sys, .rstn, .ce, .rst_pin_in, .rst_pin_out_r, .rst_pin_oe_r,
		.int_reset_req, .mode_req, .wake_event, .powerdown_wake_timing,
		.clock_multiplier_select, .fetch_addr, .core_reset_n_r, .clk_enable_r, .clk_mult_r,
		.pll_enable_r, .test_mode_r, .mode_r, .reset_vector_r, .ext_vector_r,
		.addr_external_r, .pull_active_r);
	task give_verdict;
		$display("fail_count=%0d checked=%0d", fail_count, checked);
		if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [23:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// A used-up wait counts as a mismatch
	task tmo(input int n, lim);
		if (n >= lim) begin
			fail_count++;
			give_verdict();
		end
	endtask
	// Board reset from mode m, m zero meaning run
	task sc_pin(input logic [1:0] m);
		mode_req = m;
		step(1);
		mode_req = 0;
		step(2);
		go = 1;
		step(1);
		go = 0;
		step(4);
		chk(rst_pin_oe_r, 1);
		chk(core_reset_n_r, 0);
		chk(mode_r, 0);
		for (i = 0; i < 200 && core_reset_n_r !== 1'b1; i++) step(1);
		tmo(i, 200);
		chk(i > 30, 1);
	endtask
	task sc_int;
		int_reset_req = 1;
		step(1);
		int_reset_req = 0;
		for (i = 0; i < 4 && rst_pin_oe_r !== 1'b1; i++) step(1);
		tmo(i, 4);
		for (i = 0; i < 60 && rst_pin_oe_r === 1'b1; i++) step(1);
		chk(i >= 30 && i <= 36, 1);
		for (i = 0; i < 9 && core_reset_n_r !== 1'b1; i++) step(1);
		tmo(i, 9);
	endtask
	task sc_wake;
		mode_req = 2'h3;
		step(1);
		mode_req = 0;
		step(2);
		chk(mode_r, 2'h3);
		chk(clk_enable_r, 0);
		wake_event = 1;
		step(1);
		wake_event = 0;
		for (i = 0; i < 99 && clk_enable_r !== 1'b1; i++) step(1);
		chk(i >= 14 && i <= 18, 1);
	endtask
	initial begin
		step(12);
		rstn = 1;
		step(1);
		chk(reset_vector_r, 24'hff2080);
		chk(ext_vector_r, 20'hf2080);
		chk(core_reset_n_r, 1);
		sc_pin(0);
		sc_int();
		sc_wake();
		for (int m = 1; m < 4; m++) sc_pin(m);
		for (int c = 0; c < 4; c++) begin
			clock_multiplier_select = c;
			step(2);
			chk({clk_mult_r, pll_enable_r, test_mode_r}, {c[1:0], c[1], c == 1});
		end
		// Clock enable low must freeze the select copy
		ce = 0;
		clock_multiplier_select = 0;
		step(3);
		chk(clk_mult_r, 2'h3);
		ce = 1;
		step(2);
		chk(clk_mult_r, 2'h0);
		for (int k = 0; k < 4; k++) begin
			fetch_addr = adr[k];
			step(2);
			chk(addr_external_r, k == 1 || k == 2);
		end
		give_verdict();
	end
endmodule // tb_reset_and_powerdown_wake
